// [sfe_pkg.sv]
`default_nettype none
package sfe_pkg;
   // Reference clock rate, in MHz
   localparam longint CLK_MHZ = 100;
   // Width of the self-timed cycle counter; 250 s needs 35 bits
   localparam int TIMER_W = 40;

   // Command bytes, most significant bit first on the serial input
   localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
   localparam logic [7:0] OP_WRITE_BYTES = 8'h02;
   localparam logic [7:0] OP_READ_BYTES = 8'h03;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_READ_STATUS = 8'h05;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_BULK_ERASE = 8'hC7;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;

   // Status byte layout
   localparam int STAT_WIP_BIT = 0;
   localparam int STAT_WEL_BIT = 1;
   // Value of every byte after an erase
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   // Bytes on the wire for each framed command, opcode included
   localparam logic [2:0] LEN_OPCODE_ONLY = 3'h1;
   localparam logic [2:0] LEN_STATUS_WRITE = 3'h2;
   localparam logic [2:0] LEN_LAST_ADDR = 3'h3;
   localparam logic [2:0] LEN_SECTOR_ERASE = 3'h4;
   localparam logic [2:0] LEN_WRITE_MIN = 3'h5;

   // Memory geometry: 1 Mbit array, 64 KB sectors
   localparam int MEM_AW = 17;
   localparam int SECTOR_W = 16;

   // Self-timed cycle times in microseconds, typical and longest
   localparam longint SECTOR_ERASE_TIME_TYP_US = 2000000;
   localparam longint SECTOR_ERASE_TIME_MAX_US = 3000000;
   localparam longint SECTOR_ERASE_TIME_MAX_128_US = 6000000;
   localparam longint BULK_ERASE_TIME_TYP_US = 3000000;
   localparam longint BULK_ERASE_TIME_MAX_US = 6000000;
   localparam longint BULK_ERASE_TIME_MAX_4_US = 10000000;
   localparam longint BULK_ERASE_TIME_MAX_16_US = 40000000;
   localparam longint BULK_ERASE_TIME_MAX_64_US = 160000000;
   localparam longint BULK_ERASE_TIME_MAX_128_US = 250000000;
   localparam longint PAGE_WRITE_TIME_TYP_US = 1500;
   localparam longint PAGE_WRITE_TIME_MAX_US = 5000;
   localparam longint PAGE_WRITE_TIME_MAX_128_US = 7000;
   localparam longint STATUS_WRITE_TIME_TYP_US = 5000;
   localparam longint STATUS_WRITE_TIME_MAX_US = 15000;

   // Cycle counts run at the typical time, which stays below every maximum
   localparam logic [TIMER_W-1:0] SECTOR_ERASE_CYC =
      TIMER_W'(SECTOR_ERASE_TIME_TYP_US * CLK_MHZ);
   localparam logic [TIMER_W-1:0] BULK_ERASE_CYC =
      TIMER_W'(BULK_ERASE_TIME_TYP_US * CLK_MHZ);
   localparam logic [TIMER_W-1:0] PAGE_WRITE_CYC =
      TIMER_W'(PAGE_WRITE_TIME_TYP_US * CLK_MHZ);
   localparam logic [TIMER_W-1:0] STATUS_WRITE_CYC =
      TIMER_W'(STATUS_WRITE_TIME_TYP_US * CLK_MHZ);

   // Pin synchroniser lanes and their reset levels
   localparam int PIN_SCLK = 0;
   localparam int PIN_CS = 1;
   localparam int PIN_DIN = 2;
   localparam logic [2:0] PIN_RESET = 3'h2;
endpackage
`default_nettype wire

// [sfe_sync.sv]
`default_nettype none
module sfe_sync #(
   parameter int W = 3,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // Three stages per lane plus the accepted level
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } sfe_sync_type;

   sfe_sync_type r_reg;
   sfe_sync_type r_next;

   // Accept a lane only when stages two and three agree; stage one is left alone
   always_comb begin
      r_next = r_reg;
      r_next.s1 = d;
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
      for (int i = 0; i < W; i++) begin
         if (r_reg.s2[i] == r_reg.s3[i]) begin
            r_next.q[i] = r_reg.s3[i];
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= {INIT, INIT, INIT, INIT};
      end else begin
         r_reg <= r_next;
      end
   end

   assign q = r_reg.q;
endmodule
`default_nettype wire

// [sfe_timer.sv]
`default_nettype none
module sfe_timer #(
   parameter int W = 40
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [W-1:0] count,
   output logic busy
);
   // Remaining cycles and running flag
   typedef struct packed {
      logic [W-1:0] cnt;
      logic busy;
   } sfe_timer_type;

   sfe_timer_type r_reg;
   sfe_timer_type r_next;

   // A zero count still runs one cycle so busy is always seen
   always_comb begin
      r_next = r_reg;
      if (load) begin
         r_next.cnt = (count == '0) ? W'(1) : count;
         r_next.busy = 1'b1;
      end else if (r_reg.busy) begin
         r_next.cnt = r_reg.cnt - W'(1);
         if (r_reg.cnt == W'(1)) begin
            r_next.busy = 1'b0;
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign busy = r_reg.busy;
endmodule
`default_nettype wire

// [sfe_top.sv]
`default_nettype none
module sfe_top
   import sfe_pkg::*;
#(
   parameter int MEM_AW_P = sfe_pkg::MEM_AW,
   parameter int SECTOR_W_P = sfe_pkg::SECTOR_W,
   parameter logic [sfe_pkg::TIMER_W-1:0] SECTOR_ERASE_CYC_P = sfe_pkg::SECTOR_ERASE_CYC,
   parameter logic [sfe_pkg::TIMER_W-1:0] BULK_ERASE_CYC_P = sfe_pkg::BULK_ERASE_CYC,
   parameter logic [sfe_pkg::TIMER_W-1:0] PAGE_WRITE_CYC_P = sfe_pkg::PAGE_WRITE_CYC,
   parameter logic [sfe_pkg::TIMER_W-1:0] STATUS_WRITE_CYC_P = sfe_pkg::STATUS_WRITE_CYC
) (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic SERIAL_CLK,
   input wire logic CHIP_SEL_N,
   input wire logic SERIAL_CMD_IN,
   output logic DATA_OUT,
   output logic DATA_OE,
   output logic ACTIVE_MODE
);
   import sfe_pkg::*;

   // Frame phase of the serial decoder
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_OPCODE,
      ST_ADDR,
      ST_ARGS,
      ST_STATUS,
      ST_READ,
      ST_IGNORE
   } sfe_phase_type;

   // Self-timed operation in progress
   typedef enum logic [2:0] {
      OP_NONE,
      OP_SECTOR,
      OP_BULK,
      OP_PAGE,
      OP_STATUS
   } sfe_op_type;

   // Whole state of the sequencer
   typedef struct packed {
      sfe_phase_type phase;
      logic [7:0] opcode;
      logic [7:0] shreg;
      logic [2:0] bit_cnt;
      logic [2:0] byte_cnt;
      logic [23:0] addr;
      logic [7:0] wr_data;
      logic wel;
      logic wip;
      sfe_op_type op;
      logic walking;
      logic [MEM_AW_P-1:0] ptr;
      logic [MEM_AW_P-1:0] rd_addr;
      logic [7:0] out_sh;
      logic [2:0] out_cnt;
      logic data_out;
      logic data_oe;
      logic sclk_d;
      logic cs_d;
   } sfe_state_type;

   sfe_state_type r_reg;
   sfe_state_type r_next;

   logic [2:0] pins_s; // Filtered pin levels
   logic sclk_s; // Filtered serial clock
   logic cs_s; // Filtered chip select, high is deselected
   logic din_s; // Filtered serial command input
   logic timer_busy; // Self-timed cycle still counting
   logic timer_load; // Start pulse for the cycle timer
   logic [TIMER_W-1:0] timer_count; // Length of the cycle being started
   logic mem_we; // Array write strobe
   logic [MEM_AW_P-1:0] mem_wa; // Array write address
   logic [7:0] mem_wd; // Array write data
   logic [7:0] mem_rd; // Array read data at the read pointer

   // Storage array; no reset, contents are whatever was last written
   logic [7:0] mem [0:(2**MEM_AW_P)-1];

   // Status byte as the host sees it
   function automatic logic [7:0] status_byte(input logic wel, input logic wip);
      logic [7:0] s;
      s = 8'h00;
      s[STAT_WEL_BIT] = wel;
      s[STAT_WIP_BIT] = wip;
      return s;
   endfunction

   // Pins come from another domain, so each passes the three-stage filter
   sfe_sync #(
      .W(3),
      .INIT(PIN_RESET)
   ) u_sync (
      .clk(REF_CLK),
      .rst_n(RSTN),
      .d({SERIAL_CMD_IN, CHIP_SEL_N, SERIAL_CLK}),
      .q(pins_s)
   );

   assign sclk_s = pins_s[PIN_SCLK];
   assign cs_s = pins_s[PIN_CS];
   assign din_s = pins_s[PIN_DIN];

   // One counter times every self-timed cycle
   sfe_timer #(
      .W(TIMER_W)
   ) u_timer (
      .clk(REF_CLK),
      .rst_n(RSTN),
      .load(timer_load),
      .count(timer_count),
      .busy(timer_busy)
   );

   assign mem_rd = mem[r_reg.rd_addr];

   // Next-state logic: pin edges, byte assembly, commit on select rise, cycles
   always_comb begin
      logic sclk_rise;
      logic sclk_fall;
      logic cs_fall;
      logic cs_rise;
      logic [7:0] rx_byte;
      logic [7:0] src;
      logic on_boundary;
      sclk_rise = 1'b0;
      sclk_fall = 1'b0;
      cs_fall = 1'b0;
      cs_rise = 1'b0;
      rx_byte = 8'h00;
      src = 8'h00;
      on_boundary = 1'b0;
      r_next = r_reg;
      timer_load = 1'b0;
      timer_count = '0;
      mem_we = 1'b0;
      mem_wa = r_reg.ptr;
      mem_wd = ERASED_BYTE;

      r_next.sclk_d = sclk_s;
      r_next.cs_d = cs_s;
      sclk_rise = sclk_s & ~r_reg.sclk_d;
      sclk_fall = ~sclk_s & r_reg.sclk_d;
      cs_fall = ~cs_s & r_reg.cs_d;
      cs_rise = cs_s & ~r_reg.cs_d;

      // Erase walk: one byte per clock, far faster than the timed cycle
      if (r_reg.walking) begin
         mem_we = 1'b1;
         r_next.ptr = r_reg.ptr + MEM_AW_P'(1);
         if (r_reg.op == OP_BULK) begin
            r_next.walking = ~(&r_reg.ptr);
         end else begin
            r_next.walking = ~(&r_reg.ptr[SECTOR_W_P-1:0]);
         end
      end

      // Busy drops only when both the timer and the walk are done
      if (r_reg.wip && !timer_busy && !r_reg.walking) begin
         r_next.wip = 1'b0;
         r_next.op = OP_NONE;
      end

      if (cs_fall) begin
         // New frame
         r_next.phase = ST_OPCODE;
         r_next.bit_cnt = 3'h0;
         r_next.byte_cnt = 3'h0;
         r_next.out_cnt = 3'h0;
      end else if (cs_rise) begin
         // Frame end: commit only if the last byte was whole
         r_next.phase = ST_IDLE;
         r_next.data_oe = 1'b0;
         on_boundary = (r_reg.bit_cnt == 3'h0);
         if (r_reg.phase == ST_ARGS && on_boundary && !r_reg.wip) begin
            case (r_reg.opcode)
               OP_WRITE_ENABLE: begin
                  if (r_reg.byte_cnt == LEN_OPCODE_ONLY) begin
                     r_next.wel = 1'b1;
                  end
               end
               OP_WRITE_DISABLE: begin
                  if (r_reg.byte_cnt == LEN_OPCODE_ONLY) begin
                     r_next.wel = 1'b0;
                  end
               end
               OP_SECTOR_ERASE: begin
                  // Start at once on this rise; ignored without write enable
                  if (r_reg.byte_cnt == LEN_SECTOR_ERASE && r_reg.wel) begin
                     r_next.op = OP_SECTOR;
                     r_next.walking = 1'b1;
                     // Base of the sector; upper address bits dropped
                     r_next.ptr = {r_reg.addr[MEM_AW_P-1:SECTOR_W_P],
                                   SECTOR_W_P'(0)};
                     timer_count = SECTOR_ERASE_CYC_P;
                  end
               end
               OP_BULK_ERASE: begin
                  if (r_reg.byte_cnt == LEN_OPCODE_ONLY && r_reg.wel) begin
                     r_next.op = OP_BULK;
                     r_next.walking = 1'b1;
                     r_next.ptr = '0;
                     timer_count = BULK_ERASE_CYC_P;
                  end
               end
               OP_WRITE_BYTES: begin
                  // Only the last data byte is kept; no page buffer here
                  if (r_reg.byte_cnt >= LEN_WRITE_MIN && r_reg.wel) begin
                     r_next.op = OP_PAGE;
                     mem_we = 1'b1;
                     mem_wa = r_reg.addr[MEM_AW_P-1:0];
                     mem_wd = r_reg.wr_data;
                     timer_count = PAGE_WRITE_CYC_P;
                  end
               end
               OP_WRITE_STATUS: begin
                  // Protection bits are not modelled; only the cycle is run
                  if (r_reg.byte_cnt == LEN_STATUS_WRITE && r_reg.wel) begin
                     r_next.op = OP_STATUS;
                     timer_count = STATUS_WRITE_CYC_P;
                  end
               end
               default: begin
                  r_next.op = r_reg.op;
               end
            endcase
            if (r_next.op != OP_NONE) begin
               r_next.wip = 1'b1;
               r_next.wel = 1'b0;
               timer_load = 1'b1;
            end
         end
      end else if (!cs_s && sclk_rise && r_reg.phase != ST_IDLE) begin
         // Sample the serial input on the rising serial clock
         rx_byte = {r_reg.shreg[6:0], din_s};
         r_next.shreg = rx_byte;
         r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
         if (r_reg.bit_cnt == 3'h7) begin
            // Byte complete; count saturates for long write frames
            if (r_reg.byte_cnt != 3'h7) begin
               r_next.byte_cnt = r_reg.byte_cnt + 3'h1;
            end
            case (r_reg.phase)
               ST_OPCODE: begin
                  r_next.opcode = rx_byte;
                  if (rx_byte == OP_READ_STATUS) begin
                     r_next.phase = ST_STATUS;
                  end else if (r_reg.wip) begin
                     // Anything but status is ignored during a cycle
                     r_next.phase = ST_IGNORE;
                  end else if (rx_byte == OP_SECTOR_ERASE || rx_byte == OP_READ_BYTES ||
                               rx_byte == OP_WRITE_BYTES) begin
                     r_next.phase = ST_ADDR;
                  end else begin
                     r_next.phase = ST_ARGS;
                  end
               end
               ST_ADDR: begin
                  r_next.addr = {r_reg.addr[15:0], rx_byte};
                  if (r_reg.byte_cnt == LEN_LAST_ADDR) begin
                     if (r_reg.opcode == OP_READ_BYTES) begin
                        r_next.phase = ST_READ;
                        r_next.rd_addr = r_next.addr[MEM_AW_P-1:0];
                     end else begin
                        r_next.phase = ST_ARGS;
                     end
                  end
               end
               ST_ARGS: begin
                  r_next.wr_data = rx_byte;
               end
               default: begin
                  r_next.phase = r_reg.phase;
               end
            endcase
         end
      end

      // Output shifting on the falling serial clock, MSB first
      if (!cs_s && !cs_fall && (r_reg.phase == ST_STATUS || r_reg.phase == ST_READ)) begin
         r_next.data_oe = 1'b1;
         if (sclk_fall) begin
            if (r_reg.phase == ST_STATUS) begin
               // Live status, refreshed every byte so polling sees busy drop
               src = status_byte(r_reg.wel, r_reg.wip);
            end else begin
               src = mem_rd;
            end
            if (r_reg.out_cnt == 3'h0) begin
               r_next.data_out = src[7];
               r_next.out_sh = {src[6:0], 1'b0};
            end else begin
               r_next.data_out = r_reg.out_sh[7];
               r_next.out_sh = {r_reg.out_sh[6:0], 1'b0};
            end
            r_next.out_cnt = r_reg.out_cnt + 3'h1;
            if (r_reg.out_cnt == 3'h7 && r_reg.phase == ST_READ) begin
               r_next.rd_addr = r_reg.rd_addr + MEM_AW_P'(1);
            end
         end
      end else if (cs_s) begin
         r_next.data_oe = 1'b0;
      end
   end

   // State register
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         r_reg <= '{phase: ST_IDLE, op: OP_NONE, sclk_d: 1'b0, cs_d: 1'b1, default: '0};
      end else begin
         r_reg <= r_next;
      end
   end

   // Array write port
   always_ff @(posedge REF_CLK) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   assign DATA_OUT = r_reg.data_out;
   assign DATA_OE = r_reg.data_oe;
   // Standby only when deselected and no cycle is running
   // The commit cycle is covered by the delayed select, so an erase start never dips
   assign ACTIVE_MODE = ~cs_s | ~r_reg.cs_d | r_reg.wip;
endmodule
`default_nettype wire

// [dummy_end_marker_none.sv]
`default_nettype none
`default_nettype wire

// [sfe_top_chk_sva.sv]
`default_nettype none
module sfe_top_chk
   import sfe_pkg::*;
#(
   parameter int MEM_AW_P = 17,
   parameter logic [TIMER_W-1:0] SECTOR_ERASE_CYC_P = '0,
   parameter logic [TIMER_W-1:0] BULK_ERASE_CYC_P = '0,
   parameter logic [TIMER_W-1:0] PAGE_WRITE_CYC_P = '0,
   parameter logic [TIMER_W-1:0] STATUS_WRITE_CYC_P = '0
) (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic SERIAL_CLK,
   input wire logic CHIP_SEL_N,
   input wire logic SERIAL_CMD_IN,
   input wire logic DATA_OUT,
   input wire logic DATA_OE,
   input wire logic ACTIVE_MODE
);
   timeunit 1ns;
   timeprecision 1ps;
   // Loose ceiling: every timer plus a whole-array walk plus filter slack
   localparam logic [47:0] BUSY_LIMIT = 48'(SECTOR_ERASE_CYC_P) + 48'(BULK_ERASE_CYC_P)
      + 48'(PAGE_WRITE_CYC_P) + 48'(STATUS_WRITE_CYC_P) + (48'h1 << MEM_AW_P) + 48'h20;
   logic [47:0] busy_cnt_reg; // Cycles deselected yet still active
   logic [3:0] rise_cnt_reg; // Raw link clock rises in this frame
   logic sclk_reg; // Last sampled link clock

   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RSTN);

   // Helper counters; rise count saturates so long frames cannot wrap
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         busy_cnt_reg <= '0;
         rise_cnt_reg <= '0;
         sclk_reg <= 1'b0;
      end else begin
         sclk_reg <= SERIAL_CLK;
         busy_cnt_reg <= (CHIP_SEL_N && ACTIVE_MODE) ? busy_cnt_reg + 48'h1 : '0;
         if (CHIP_SEL_N) begin
            rise_cnt_reg <= '0;
         end else if (SERIAL_CLK && !sclk_reg && rise_cnt_reg != 4'hF) begin
            rise_cnt_reg <= rise_cnt_reg + 4'h1;
         end
      end
   end

   property p_sel_active;
      (!CHIP_SEL_N) [*6] |-> ACTIVE_MODE;
   endproperty
   a_sel_active: assert property (p_sel_active)
      else $error("active mode missing while selected");
   property p_wake_on_sel;
      $rose(ACTIVE_MODE) |-> !$past(CHIP_SEL_N, 2);
   endproperty
   a_wake_on_sel: assert property (p_wake_on_sel)
      else $error("active mode rose without select");
   property p_stay_standby;
      CHIP_SEL_N && !ACTIVE_MODE |=> !ACTIVE_MODE;
   endproperty
   a_stay_standby: assert property (p_stay_standby)
      else $error("left standby while deselected");
   property p_oe_active;
      DATA_OE |-> ACTIVE_MODE || $past(ACTIVE_MODE);
   endproperty
   a_oe_active: assert property (p_oe_active)
      else $error("output driven in standby");
   property p_busy_bound;
      busy_cnt_reg <= BUSY_LIMIT;
   endproperty
   a_busy_bound: assert property (p_busy_bound)
      else $error("self-timed cycle overran its limit");
   property p_oe_after_opcode;
      $rose(DATA_OE) |-> rise_cnt_reg >= 4'h8;
   endproperty
   a_oe_after_opcode: assert property (p_oe_after_opcode)
      else $error("output enabled before a whole opcode");
   property p_oe_release;
      $fell(DATA_OE) |-> $past(CHIP_SEL_N, 3);
   endproperty
   a_oe_release: assert property (p_oe_release)
      else $error("output released while still selected");
   property p_dout_on_fall;
      $changed(DATA_OUT) && DATA_OE |-> !$past(SERIAL_CLK, 3);
   endproperty
   a_dout_on_fall: assert property (p_dout_on_fall)
      else $error("data out moved away from a clock fall");

   c_busy: cover property (CHIP_SEL_N && ACTIVE_MODE);
   c_read: cover property ($rose(DATA_OE));
   c_standby: cover property ($fell(ACTIVE_MODE) && CHIP_SEL_N);
endmodule

bind sfe_top sfe_top_chk #(
   .MEM_AW_P(MEM_AW_P),
   .SECTOR_ERASE_CYC_P(SECTOR_ERASE_CYC_P),
   .BULK_ERASE_CYC_P(BULK_ERASE_CYC_P),
   .PAGE_WRITE_CYC_P(PAGE_WRITE_CYC_P),
   .STATUS_WRITE_CYC_P(STATUS_WRITE_CYC_P)
) u_chk (
   .REF_CLK(REF_CLK),
   .RSTN(RSTN),
   .SERIAL_CLK(SERIAL_CLK),
   .CHIP_SEL_N(CHIP_SEL_N),
   .SERIAL_CMD_IN(SERIAL_CMD_IN),
   .DATA_OUT(DATA_OUT),
   .DATA_OE(DATA_OE),
   .ACTIVE_MODE(ACTIVE_MODE)
);
`default_nettype wire

// [sfe_host_model.sv]
`default_nettype none
module sfe_host_model (
   input wire logic clk,
   output logic sclk,
   output logic sel_n,
   output logic cmd,
   input wire logic dout
);
   timeunit 1ns;
   timeprecision 1ps;
   // Half period in system clocks: 40 ns, so a 12.5 MHz link clock
   localparam int HALF = 4;
   // Idle: link clock parked low, deselected
   initial begin
      sclk = 1'b0;
      sel_n = 1'b1;
      cmd = 1'b1;
   end
   // Shift nbits of tx MSB first; rx keeps the last eight bits read back
   task automatic frame(input int nbits, input logic [39:0] tx, output logic [7:0] rx);
      rx = 8'h00;
      @(posedge clk) sel_n <= 1'b0;
      repeat (HALF) @(posedge clk);
      for (int i = 0; i < nbits; i++) begin
         cmd <= tx[39 - i];
         repeat (HALF) @(posedge clk);
         sclk <= 1'b1;
         repeat (HALF) @(posedge clk);
         // Sample late in the high phase, long after the previous fall
         rx = {rx[6:0], dout};
         sclk <= 1'b0;
      end
      repeat (HALF) @(posedge clk);
      sel_n <= 1'b1;
      // Released line shows the inverse so a stale level never looks valid
      cmd <= ~cmd;
      repeat (3 * HALF) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// [tb_serial_flash_sector_erase.sv]
`default_nettype none
module tb_serial_flash_sector_erase;
   timeunit 1ns;
   timeprecision 1ps;
   import sfe_pkg::*;
   // Shrunk geometry: 4 KB array, 256 byte sectors, short timers
   localparam int AW = 12;
   localparam int SW = 8;
   localparam logic [TIMER_W-1:0] ERASE_CYC = 40'h3E8;
   localparam logic [TIMER_W-1:0] WRITE_CYC = 40'h64;
   localparam logic [23:0] ADDR_A = 24'h000123; // Inside sector 1
   localparam logic [23:0] ADDR_END = 24'h0001FF; // Last byte of sector 1
   localparam logic [23:0] ADDR_B = 24'h000200; // Neighbour sector, must survive
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic sclk;
   logic sel_n;
   logic cmd;
   logic dout;
   logic doe;
   logic active;
   int n_errors = 0;
   int checks_done = 0;
   int cycles = 0;

   always #5 ref_clk = ~ref_clk;

   // Released data line reads inverted, so a stale bit is never taken as valid
   sfe_host_model u_host (.clk(ref_clk), .sclk(sclk), .sel_n(sel_n), .cmd(cmd),
      .dout(doe ? dout : ~dout));
   sfe_top #(.MEM_AW_P(AW), .SECTOR_W_P(SW), .SECTOR_ERASE_CYC_P(ERASE_CYC),
      .BULK_ERASE_CYC_P(ERASE_CYC), .PAGE_WRITE_CYC_P(WRITE_CYC),
      .STATUS_WRITE_CYC_P(WRITE_CYC)) dut (.REF_CLK(ref_clk), .RSTN(rstn),
      .SERIAL_CLK(sclk), .CHIP_SEL_N(sel_n), .SERIAL_CMD_IN(cmd), .DATA_OUT(dout),
      .DATA_OE(doe), .ACTIVE_MODE(active));

   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Byte compare; four-state so an unknown never matches
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: got %02h expected %02h", $time, got, exp);
      end
   endtask
   task automatic check1(input logic got, input logic exp);
      check8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic op(input logic [7:0] code);
      logic [7:0] r;
      u_host.frame(8, {code, 32'h0}, r);
   endtask
   task automatic status(output logic [7:0] s);
      u_host.frame(16, {OP_READ_STATUS, 32'h0}, s);
   endtask
   task automatic expect_at(input logic [23:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_host.frame(40, {OP_READ_BYTES, a, 8'h00}, d);
      check8(d, exp);
   endtask
   // Poll status a bounded number of times until the cycle is over
   task automatic wait_idle;
      logic [7:0] s;
      int k;
      k = 0;
      status(s);
      while (s[STAT_WIP_BIT] !== 1'b0 && k < 40) begin
         status(s);
         k++;
      end
      check1(s[STAT_WIP_BIT], 1'b0);
   endtask
   task automatic write_at(input logic [23:0] a, input logic [7:0] d);
      logic [7:0] r;
      op(OP_WRITE_ENABLE);
      u_host.frame(40, {OP_WRITE_BYTES, a, d}, r);
      wait_idle();
   endtask

   task automatic t_reset;
      logic [7:0] s;
      check1(active, 1'b0);
      check1(doe, 1'b0);
      status(s);
      check8(s, 8'h00);
      write_at(ADDR_A, 8'h5A);
      write_at(ADDR_END, 8'hC3);
      write_at(ADDR_B, 8'h3C);
      $display("test reset done");
   endtask
   // Erase without the latch set must leave everything alone
   task automatic t_no_enable;
      logic [7:0] s;
      u_host.frame(32, {OP_SECTOR_ERASE, ADDR_A, 8'h00}, s);
      status(s);
      check8(s, 8'h00);
      expect_at(ADDR_A, 8'h5A);
      $display("test no_enable done");
   endtask
   // Cut short, too short and too long frames are all dropped
   task automatic t_bad_frame;
      logic [7:0] s;
      int lens[3] = '{31, 24, 40};
      op(OP_WRITE_ENABLE);
      status(s);
      check8(s, 8'h02);
      foreach (lens[i]) begin
         u_host.frame(lens[i], {OP_SECTOR_ERASE, ADDR_A, 8'h00}, s);
         status(s);
         check8(s, 8'h02);
         expect_at(ADDR_A, 8'h5A);
      end
      op(OP_WRITE_DISABLE);
      $display("test bad_frame done");
   endtask
   // Real erase with junk above the array width, then the side effects
   task automatic t_erase;
      logic [7:0] s;
      op(OP_WRITE_ENABLE);
      u_host.frame(32, {OP_SECTOR_ERASE, 24'hFFF147, 8'h00}, s);
      check1(active, 1'b1);
      op(OP_WRITE_ENABLE);
      status(s);
      check8(s, 8'h01);
      wait_idle();
      check1(active, 1'b0);
      status(s);
      check8(s, 8'h00);
      expect_at(ADDR_A, ERASED_BYTE);
      expect_at(24'h000100, ERASED_BYTE);
      expect_at(ADDR_END, ERASED_BYTE);
      expect_at(ADDR_B, 8'h3C);
      $display("test erase done");
   endtask
   // Status write, bulk erase, then a restart pulse while idle with the write enable latch set
   task automatic t_misc;
      logic [7:0] s;
      op(OP_WRITE_ENABLE);
      u_host.frame(16, {OP_WRITE_STATUS, 8'h00, 24'h0}, s);
      status(s);
      check8(s, 8'h01);
      wait_idle();
      op(OP_WRITE_ENABLE);
      op(OP_BULK_ERASE);
      wait_idle();
      status(s);
      check8(s, 8'h00);
      expect_at(ADDR_B, ERASED_BYTE);
      op(OP_WRITE_ENABLE);
      rstn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (6) @(posedge ref_clk);
      check1(active, 1'b0);
      status(s);
      check8(s, 8'h00);
      $display("test misc done");
   endtask

   // Hang guard, well above the roughly 15000 cycles the tests need
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 30000) begin
         n_errors++;
         $display("timeout at %0t", $time);
         report_and_stop();
      end
   end

   initial begin
      repeat (16) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (6) @(posedge ref_clk);
      t_reset();
      t_no_enable();
      t_bad_frame();
      t_erase();
      t_misc();
      report_and_stop();
   end
endmodule
`default_nettype wire
